// file: shared/radio_autocal_consts.svh
// Offsets, field positions, reset values and timing counts of the radio config block
`ifndef RADIO_AUTOCAL_CONSTS_SVH
`define RADIO_AUTOCAL_CONSTS_SVH

`define CFG0_OFFSET     8'h18
`define TUNE_OFFSET     8'h20
`define CTRL_OFFSET     8'h24
`define STATUS_OFFSET   8'h28

`define CFG0_RESET      8'h04
`define TUNE_RESET      8'hf8
`define CTRL_RESET      8'h00

`define CFG0_RW_MASK    8'h3f
`define TUNE_RW_MASK    8'hfb
`define CTRL_RW_MASK    8'h03

`define CFG0_FORCE_BIT  0
`define CFG0_PO_LSB     2
`define CFG0_CAL_LSB    4

`define CLK_PERIOD_NS   100
`define PO_TICK_NS      2300
`define PO_TICK_CYCLES  ((`PO_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CYCLES      8
`define AUTO_CAL_EVERY  4

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// file: shared/radio_autocal_pkg.sv
// Types of the radio state machine configuration block
`default_nettype none

package radio_autocal_pkg;

	typedef enum logic [2:0] {
		ST_SLEEP  = 3'h0,
		ST_IDLE   = 3'h1,
		ST_CAL    = 3'h3,
		ST_SYNTH_ON_TX_READY_STATE = 3'h2,
		ST_TX     = 3'h6
	} radio_state_t;

	typedef enum logic [1:0] {
		CAL_NEVER       = 2'h0,
		CAL_FROM_IDLE   = 2'h1,
		CAL_TO_IDLE     = 2'h2,
		CAL_EVERY_4TH   = 2'h3
	} autocal_mode_t;

	typedef enum logic [1:0] {
		AFTER_TX_IDLE     = 2'h0,
		AFTER_TX_SYNTH_ON_TX_READY_STATE   = 2'h1,
		AFTER_TX_STAY     = 2'h2,
		AFTER_TX_RESERVED = 2'h3
	} after_tx_t;

endpackage

`default_nettype wire

// file: logic/pin_sync.sv
// Three-flop input synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output var  logic level_q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

endmodule // pin_sync

`default_nettype wire

// file: logic/powerup_timer.sv
// Power-on timeout counter gating the oscillator-stable and chip-ready indications
`timescale 1ns/1ps
`default_nettype none

module powerup_timer #(
	parameter int unsigned TICK_CYCLES = 23
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       osc_running,
	input  wire logic [1:0] timeout_sel,
	output var  logic       osc_stable_flag,
	output var  logic       chip_ready_low
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	logic [TW-1:0] tick_q;
	logic [8:0]    expire_q;
	logic [8:0]    target;
	logic          tick_end;
	logic [15:0]   wait_cnt_q;

	always_comb begin
		case (timeout_sel)
			2'h0:    target = 9'h001;
			2'h1:    target = 9'h010;
			2'h2:    target = 9'h040;
			default: target = 9'h100;
		endcase
	end

	assign tick_end = (tick_q == TW'(TICK_CYCLES - 1));

	// Counts timer expirations from oscillator start
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_q   <= '0;
			expire_q <= '0;
		end else if (!osc_running || osc_stable_flag) begin
			tick_q   <= '0;
			expire_q <= '0;
		end else if (tick_end) begin
			tick_q   <= '0;
			expire_q <= expire_q + 9'h001;
		end else begin
			tick_q <= tick_q + TW'(1);
		end
	end

	// Both indications come from the same condition on the same edge
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			osc_stable_flag <= 1'b0;
			chip_ready_low  <= 1'b1;
		end else if (!osc_running) begin
			osc_stable_flag <= 1'b0;
			chip_ready_low  <= 1'b1;
		end else if (tick_end && expire_q == target - 9'h001) begin
			osc_stable_flag <= 1'b1;
			chip_ready_low  <= 1'b0;
		end
	end

	// Cycles spent waiting, watched by the checks below
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cnt_q <= '0;
		end else if (!osc_running) begin
			wait_cnt_q <= '0;
		end else if (!osc_stable_flag) begin
			wait_cnt_q <= wait_cnt_q + 16'h0001;
		end
	end

	a_timeout_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
		($rose(osc_stable_flag) && $stable(timeout_sel))
			|-> 32'(wait_cnt_q) == 32'(target) * TICK_CYCLES)
		else $error("power-on timeout length wrong");

	a_timeout_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(osc_stable_flag) |-> 32'(wait_cnt_q) >= TICK_CYCLES)
		else $error("ready before one timer expiration");

	a_ready_together: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(osc_stable_flag) |-> $changed(chip_ready_low)
			&& osc_stable_flag != chip_ready_low)
		else $error("stable and chip ready separated");

	c_ready_seen: cover property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(osc_stable_flag));

endmodule // powerup_timer

`default_nettype wire

// file: logic/radio_state_autocal_config.sv
// Radio state machine with synthesizer autocalibration, power-on timeout and AXI4-Lite registers
//
// How it works
// - Select 00: no automatic calibration; only the manual calibrate strobe calibrates.
// - Select 01: calibrate on every idle to transmit or synth-on-ready transition.
// - Select 10: calibrate on each automatic return from transmit to idle.
// - Select 11: count automatic returns, calibrate on every fourth one.
// - Timeout field picks 1, 16, 64 or 256 timer expirations before ready.
// - One expiration lasts about 2.3 to 2.4 us, scaling with crystal period.
// - Oscillator-stable and chip-ready-low change on the same cycle.
// - Force bit keeps the crystal oscillator running in sleep.
// - After-transmit field picks idle, synth-on-ready, or stay and restart preamble.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "radio_autocal_consts.svh"

module radio_state_autocal_config #(
	parameter int unsigned TICK_CYCLES = `PO_TICK_CYCLES,
	parameter int unsigned CAL_CYCLES  = `CAL_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	input  wire logic        manual_calibrate_strobe,
	input  wire logic        tx_strobe,
	input  wire logic        synth_on_tx_ready_state_strobe,
	input  wire logic        idle_strobe,
	input  wire logic        sleep_strobe,
	input  wire logic        packet_done,
	input  wire logic        osc_running_pin,
	output var  logic        osc_enable,
	output var  logic        osc_stable_flag,
	output var  logic        chip_ready_low,
	output var  logic [2:0]  radio_state,
	output var  logic        preamble_restart
);

	localparam int CW = $clog2(CAL_CYCLES + 1);

	logic [7:0]  cfg0_q;
	logic [7:0]  tune_q;
	logic [7:0]  ctrl_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  wr_addr_q;
	logic [7:0]  wr_data_q;
	logic        wr_lane_q;
	logic [7:0]  rd_addr_q;
	logic        wr_go;
	logic        osc_running;
	logic [CW-1:0] cal_cnt_q;
	logic [1:0]  ret_cnt_q;
	logic        auto_ret;
	logic        cal_on_return;
	logic        idle_start;

	radio_autocal_pkg::radio_state_t  state_q;
	radio_autocal_pkg::radio_state_t  after_cal_q;
	radio_autocal_pkg::radio_state_t  idle_target;
	radio_autocal_pkg::autocal_mode_t cal_mode;
	radio_autocal_pkg::after_tx_t     after_tx_next_state;

	assign cal_mode            = radio_autocal_pkg::autocal_mode_t'(cfg0_q[`CFG0_CAL_LSB +: 2]);
	assign after_tx_next_state = radio_autocal_pkg::after_tx_t'(ctrl_q[1:0]);
	assign radio_state         = state_q;

	function automatic logic mapped(input logic [7:0] a);
		mapped = ({a[7:2], 2'b00} == `CFG0_OFFSET) || ({a[7:2], 2'b00} == `TUNE_OFFSET)
			|| ({a[7:2], 2'b00} == `CTRL_OFFSET) || ({a[7:2], 2'b00} == `STATUS_OFFSET);
	endfunction

	pin_sync u_osc_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.pin_in  (osc_running_pin),
		.level_q (osc_running)
	);

	powerup_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_po_timer (
		.sys_clk         (sys_clk),
		.sys_rst         (sys_rst),
		.osc_running     (osc_running),
		.timeout_sel     (cfg0_q[`CFG0_PO_LSB +: 2]),
		.osc_stable_flag (osc_stable_flag),
		.chip_ready_low  (chip_ready_low)
	);

	// Write address and data channels, taken in either order
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			awready   <= 1'b0;
			aw_have_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			aw_have_q <= 1'b1;
			wr_addr_q <= awaddr;
		end else if (bvalid && bready) begin
			awready   <= 1'b1;
			aw_have_q <= 1'b0;
		end else if (!aw_have_q && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wready    <= 1'b0;
			w_have_q  <= 1'b0;
			wr_data_q <= 8'h00;
			wr_lane_q <= 1'b0;
		end else if (wvalid && wready) begin
			wready    <= 1'b0;
			w_have_q  <= 1'b1;
			wr_data_q <= wdata[7:0];
			wr_lane_q <= wstrb[0];
		end else if (bvalid && bready) begin
			wready   <= 1'b1;
			w_have_q <= 1'b0;
		end else if (!w_have_q && !bvalid) begin
			wready <= 1'b1;
		end
	end

	assign wr_go = aw_have_q && w_have_q && !bvalid;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= mapped(wr_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Register storage; unused bits never store
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg0_q <= `CFG0_RESET;
			tune_q <= `TUNE_RESET;
			ctrl_q <= `CTRL_RESET;
		end else if (wr_go && wr_lane_q) begin
			if ({wr_addr_q[7:2], 2'b00} == `CFG0_OFFSET) begin
				cfg0_q <= wr_data_q & `CFG0_RW_MASK;
			end
			if ({wr_addr_q[7:2], 2'b00} == `TUNE_OFFSET) begin
				tune_q <= wr_data_q & `TUNE_RW_MASK;
			end
			if ({wr_addr_q[7:2], 2'b00} == `CTRL_OFFSET) begin
				ctrl_q <= wr_data_q & `CTRL_RW_MASK;
			end
		end
	end

	// Read channel
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			arready   <= 1'b0;
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= `RESP_OKAY;
			rd_addr_q <= 8'h00;
		end else if (arvalid && arready) begin
			arready   <= 1'b0;
			rvalid    <= 1'b1;
			rd_addr_q <= araddr;
			rresp     <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			case ({araddr[7:2], 2'b00})
				`CFG0_OFFSET:   rdata <= {24'h000000, cfg0_q};
				`TUNE_OFFSET:   rdata <= {24'h000000, tune_q};
				`CTRL_OFFSET:   rdata <= {24'h000000, ctrl_q};
				`STATUS_OFFSET: rdata <= {25'h0, osc_running, ret_cnt_q,
					osc_stable_flag, state_q};
				default:        rdata <= 32'h00000000;
			endcase
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	assign idle_start  = state_q == radio_autocal_pkg::ST_IDLE && !sleep_strobe
		&& !manual_calibrate_strobe && (tx_strobe || synth_on_tx_ready_state_strobe);
	assign idle_target = tx_strobe ? radio_autocal_pkg::ST_TX : radio_autocal_pkg::ST_SYNTH_ON_TX_READY_STATE;
	assign auto_ret    = state_q == radio_autocal_pkg::ST_TX && !idle_strobe && packet_done
		&& after_tx_next_state != radio_autocal_pkg::AFTER_TX_SYNTH_ON_TX_READY_STATE
		&& after_tx_next_state != radio_autocal_pkg::AFTER_TX_STAY;
	assign cal_on_return = cal_mode == radio_autocal_pkg::CAL_TO_IDLE
		|| (cal_mode == radio_autocal_pkg::CAL_EVERY_4TH
			&& ret_cnt_q == 2'(`AUTO_CAL_EVERY - 1));

	// Main radio state machine
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= radio_autocal_pkg::ST_IDLE;
			after_cal_q <= radio_autocal_pkg::ST_IDLE;
		end else begin
			case (state_q)
				radio_autocal_pkg::ST_SLEEP: begin
					if (idle_strobe) begin
						state_q <= radio_autocal_pkg::ST_IDLE;
					end
				end
				radio_autocal_pkg::ST_IDLE: begin
					if (sleep_strobe) begin
						state_q <= radio_autocal_pkg::ST_SLEEP;
					end else if (manual_calibrate_strobe) begin
						state_q     <= radio_autocal_pkg::ST_CAL;
						after_cal_q <= radio_autocal_pkg::ST_IDLE;
					end else if (idle_start) begin
						if (cal_mode == radio_autocal_pkg::CAL_FROM_IDLE) begin
							state_q     <= radio_autocal_pkg::ST_CAL;
							after_cal_q <= idle_target;
						end else begin
							state_q <= idle_target;
						end
					end
				end
				radio_autocal_pkg::ST_SYNTH_ON_TX_READY_STATE: begin
					if (tx_strobe) begin
						state_q <= radio_autocal_pkg::ST_TX;
					end else if (idle_strobe) begin
						state_q <= radio_autocal_pkg::ST_IDLE;
					end
				end
				radio_autocal_pkg::ST_TX: begin
					if (idle_strobe) begin
						state_q <= radio_autocal_pkg::ST_IDLE;
					end else if (packet_done) begin
						case (after_tx_next_state)
							radio_autocal_pkg::AFTER_TX_SYNTH_ON_TX_READY_STATE:
								state_q <= radio_autocal_pkg::ST_SYNTH_ON_TX_READY_STATE;
							radio_autocal_pkg::AFTER_TX_STAY:
								state_q <= radio_autocal_pkg::ST_TX;
							default: begin
								if (cal_on_return) begin
									state_q     <= radio_autocal_pkg::ST_CAL;
									after_cal_q <= radio_autocal_pkg::ST_IDLE;
								end else begin
									state_q <= radio_autocal_pkg::ST_IDLE;
								end
							end
						endcase
					end
				end
				radio_autocal_pkg::ST_CAL: begin
					if (cal_cnt_q == CW'(CAL_CYCLES - 1)) begin
						state_q <= after_cal_q;
					end
				end
				default: state_q <= radio_autocal_pkg::ST_IDLE;
			endcase
		end
	end

	// Calibration duration
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cal_cnt_q <= '0;
		end else if (state_q == radio_autocal_pkg::ST_CAL) begin
			cal_cnt_q <= cal_cnt_q + CW'(1);
		end else begin
			cal_cnt_q <= '0;
		end
	end

	// Automatic return counter, wraps every fourth return
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ret_cnt_q <= 2'h0;
		end else if (auto_ret && cal_mode == radio_autocal_pkg::CAL_EVERY_4TH) begin
			ret_cnt_q <= ret_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			preamble_restart <= 1'b0;
		end else begin
			preamble_restart <= state_q == radio_autocal_pkg::ST_TX && !idle_strobe
				&& packet_done && after_tx_next_state == radio_autocal_pkg::AFTER_TX_STAY;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			osc_enable <= 1'b1;
		end else begin
			osc_enable <= state_q != radio_autocal_pkg::ST_SLEEP
				|| cfg0_q[`CFG0_FORCE_BIT];
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_no_auto_cal: assert property (
		(idle_start && cal_mode == radio_autocal_pkg::CAL_NEVER)
			|=> state_q == $past(idle_target) && state_q != radio_autocal_pkg::ST_CAL)
		else $error("calibration without request in manual mode");

	a_start_cal: assert property (
		(idle_start && cal_mode == radio_autocal_pkg::CAL_FROM_IDLE)
			|=> state_q == radio_autocal_pkg::ST_CAL && after_cal_q == $past(idle_target))
		else $error("no calibration on leaving idle");

	a_return_cal: assert property (
		(auto_ret && cal_mode == radio_autocal_pkg::CAL_TO_IDLE)
			|=> state_q == radio_autocal_pkg::ST_CAL ##CAL_CYCLES
				state_q == radio_autocal_pkg::ST_IDLE)
		else $error("no calibration on return to idle");

	a_fourth_return: assert property (
		(auto_ret && cal_mode == radio_autocal_pkg::CAL_EVERY_4TH)
			|=> (state_q == radio_autocal_pkg::ST_CAL) == ($past(ret_cnt_q) == 2'h3))
		else $error("every-fourth calibration miscounted");

	a_force_osc: assert property (
		(state_q == radio_autocal_pkg::ST_SLEEP) [*2]
			|-> osc_enable == $past(cfg0_q[`CFG0_FORCE_BIT]))
		else $error("oscillator force-on not honoured in sleep");

	a_unused_zero: assert property (
		rvalid && {rd_addr_q[7:2], 2'b00} == `CFG0_OFFSET |-> rdata[7:6] == 2'b00)
		else $error("unused config bits read nonzero");

	a_tune_zero: assert property (
		rvalid && {rd_addr_q[7:2], 2'b00} == `TUNE_OFFSET |-> rdata[2] == 1'b0)
		else $error("unused tuning bit reads nonzero");

	a_after_tx: assert property (
		(state_q == radio_autocal_pkg::ST_TX && !idle_strobe && packet_done
			&& after_tx_next_state == radio_autocal_pkg::AFTER_TX_SYNTH_ON_TX_READY_STATE)
			|=> state_q == radio_autocal_pkg::ST_SYNTH_ON_TX_READY_STATE && !preamble_restart)
		else $error("wrong state after transmit");

	c_idle_cal_tx: cover property (
		idle_start && cal_mode == radio_autocal_pkg::CAL_FROM_IDLE && tx_strobe);
	c_fourth_cal: cover property (auto_ret && cal_on_return
		&& cal_mode == radio_autocal_pkg::CAL_EVERY_4TH);
	c_preamble: cover property (preamble_restart);

endmodule // radio_state_autocal_config

`default_nettype wire

// file: dv/tb_radio_state_autocal_config.sv
// Self-checking testbench of the radio state machine configuration block
`timescale 1ns/1ps
`default_nettype none
`include "radio_autocal_consts.svh"

module tb_radio_state_autocal_config;
	localparam int unsigned TICK = 2;
	localparam int unsigned CALC = 2;
	localparam logic [2:0] S_IDLE = radio_autocal_pkg::ST_IDLE;
	localparam logic [2:0] S_CAL = radio_autocal_pkg::ST_CAL;
	localparam logic [2:0] S_TX = radio_autocal_pkg::ST_TX;
	localparam logic [2:0] S_FSTX = radio_autocal_pkg::ST_SYNTH_ON_TX_READY_STATE;
	localparam logic [2:0] S_SLEEP = radio_autocal_pkg::ST_SLEEP;

	logic        sys_clk, sys_rst;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [5:0]  stb;
	logic        osc_running_pin, osc_enable, osc_stable_flag, chip_ready_low, preamble_restart;
	logic [2:0]  radio_state;
	int          err_count, check_count;

	radio_state_autocal_config #(.TICK_CYCLES(TICK), .CAL_CYCLES(CALC)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.manual_calibrate_strobe(stb[0]), .tx_strobe(stb[1]), .synth_on_tx_ready_state_strobe(stb[2]),
		.idle_strobe(stb[3]), .sleep_strobe(stb[4]), .packet_done(stb[5]),
		.osc_running_pin(osc_running_pin), .osc_enable(osc_enable),
		.osc_stable_flag(osc_stable_flag), .chip_ready_low(chip_ready_low),
		.radio_state(radio_state), .preamble_restart(preamble_restart)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Write one register; address and data offered together, each released when taken
	task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
			input string msg);
		logic [1:0] r;
		r = 2'h3;
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
		@(posedge sys_clk);
		chk({30'h0, r}, {30'h0, er}, msg);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
			input string msg);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'hffffffff;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge sys_clk);
		chk(d, ed, msg);
		chk({30'h0, r}, {30'h0, er}, msg);
	endtask

	// One-cycle strobe: 0 cal, 1 tx, 2 synth-on, 3 idle, 4 sleep, 5 packet done
	task automatic pulse(input int k);
		stb <= 6'h01 << k;
		@(posedge sys_clk);
		stb <= 6'h00;
	endtask

	task automatic see(input logic [2:0] exp, input string msg);
		@(posedge sys_clk);
		chk({29'h0, radio_state}, {29'h0, exp}, msg);
	endtask

	task automatic cal_to(input logic [2:0] exp);
		repeat (CALC) see(S_CAL, "calibrating");
		see(exp, "after calibration");
	endtask

	task automatic sc_regs();
		rchk(`CFG0_OFFSET, 32'h00000004, `RESP_OKAY, "cfg0 reset");
		rchk(`TUNE_OFFSET, 32'h000000f8, `RESP_OKAY, "tuning reset");
		rchk(`CTRL_OFFSET, 32'h00000000, `RESP_OKAY, "ctrl reset");
		rchk(`STATUS_OFFSET, 32'h00000001, `RESP_OKAY, "status idle");
		wchk(`CFG0_OFFSET, 8'hff, `RESP_OKAY, "cfg0 write");
		rchk(`CFG0_OFFSET, 32'h0000003f, `RESP_OKAY, "cfg0 unused bits");
		wchk(`TUNE_OFFSET, 8'hff, `RESP_OKAY, "tuning write");
		rchk(`TUNE_OFFSET, 32'h000000fb, `RESP_OKAY, "tuning unused bit");
		wchk(8'h30, 8'h55, `RESP_SLVERR, "unmapped write");
		rchk(8'h30, 32'h00000000, `RESP_SLVERR, "unmapped read");
	endtask

	// Cycles from oscillator start to ready; differences cancel the synchroniser delay
	task automatic sc_powerup();
		int n;
		int n0;
		int cnt [4] = '{1, 16, 64, 256};
		n0 = 0;
		for (int k = 0; k < 4; k++) begin
			wchk(`CFG0_OFFSET, 8'(k << 2), `RESP_OKAY, "timeout select");
			osc_running_pin <= 1'b1;
			n = 0;
			while (osc_stable_flag !== 1'b1 && n < 700) begin
				@(posedge sys_clk);
				n++;
				chk({31'h0, chip_ready_low}, {31'h0, ~osc_stable_flag}, "ready pair");
			end
			if (k == 0) begin
				n0 = n;
				chk(32'(n >= TICK + 2 && n <= TICK + 6), 32'h1, "single tick");
			end
			else
				chk(32'(n - n0), 32'((cnt[k] - 1) * TICK), "timeout span");
			osc_running_pin <= 1'b0;
			n = 0;
			while (osc_stable_flag !== 1'b0 && n < 20) begin
				@(posedge sys_clk);
				n++;
				chk({31'h0, chip_ready_low}, {31'h0, ~osc_stable_flag}, "ready pair");
			end
			chk({31'h0, osc_stable_flag}, 32'h0, "stable falls");
		end
	endtask

	task automatic sc_autocal();
		wchk(`CFG0_OFFSET, 8'h04, `RESP_OKAY, "mode never");
		pulse(1);
		see(S_TX, "never tx");
		pulse(5);
		see(S_IDLE, "never return");
		pulse(0);
		cal_to(S_IDLE);
		wchk(`CFG0_OFFSET, 8'h14, `RESP_OKAY, "mode from idle");
		pulse(1);
		cal_to(S_TX);
		pulse(5);
		see(S_IDLE, "from-idle return");
		pulse(2);
		cal_to(S_FSTX);
		pulse(3);
		see(S_IDLE, "abort");
		wchk(`CFG0_OFFSET, 8'h24, `RESP_OKAY, "mode to idle");
		pulse(1);
		see(S_TX, "to-idle tx");
		pulse(5);
		cal_to(S_IDLE);
		wchk(`CFG0_OFFSET, 8'h34, `RESP_OKAY, "mode every fourth");
		for (int i = 1; i <= 4; i++) begin
			pulse(1);
			see(S_TX, "fourth tx");
			pulse(5);
			if (i == 4)
				cal_to(S_IDLE);
			else
				see(S_IDLE, "uncalibrated return");
		end
	endtask

	task automatic sc_after_tx();
		wchk(`CFG0_OFFSET, 8'h04, `RESP_OKAY, "mode never");
		wchk(`CTRL_OFFSET, 8'h01, `RESP_OKAY, "after tx synth");
		pulse(1);
		see(S_TX, "tx");
		pulse(5);
		see(S_FSTX, "after tx synth");
		pulse(3);
		see(S_IDLE, "abort");
		wchk(`CTRL_OFFSET, 8'h02, `RESP_OKAY, "after tx stay");
		pulse(1);
		see(S_TX, "tx");
		pulse(5);
		@(posedge sys_clk);
		chk({28'h0, radio_state, preamble_restart}, {28'h0, S_TX, 1'b1}, "stay");
		@(posedge sys_clk);
		chk({31'h0, preamble_restart}, 32'h0, "restart pulse width");
		pulse(3);
		see(S_IDLE, "abort");
		wchk(`CTRL_OFFSET, 8'h03, `RESP_OKAY, "after tx reserved");
		pulse(1);
		see(S_TX, "tx");
		pulse(5);
		see(S_IDLE, "reserved acts as idle");
		wchk(`CTRL_OFFSET, 8'h00, `RESP_OKAY, "after tx idle");
	endtask

	task automatic sc_sleep();
		for (int f = 0; f < 2; f++) begin
			wchk(`CFG0_OFFSET, 8'(4 + f), `RESP_OKAY, "force bit");
			pulse(4);
			see(S_SLEEP, "sleep");
			@(posedge sys_clk);
			chk({31'h0, osc_enable}, 32'(f), "oscillator in sleep");
			pulse(3);
			see(S_IDLE, "wake");
		end
	endtask

	initial begin
		err_count = 0;
		check_count = 0;
		sys_rst = 1'b1;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		stb = 6'h00;
		osc_running_pin = 1'b0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		sc_regs();
		sc_powerup();
		sc_autocal();
		sc_after_tx();
		sc_sleep();
		wrap_up();
	end

	initial begin
		#2000000;
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		wrap_up();
	end
endmodule // tb_radio_state_autocal_config
`default_nettype wire
